// File: charger_config_status_regs.sv
/*
 * Configuration and status register bank of a single-cell charger, locations
 * 03h to 05h, with the decoded settings that steer the charge controller.
 * Assumes a serial front end that presents byte-wide register reads and writes
 * on clk, pin levels that are asynchronous, and detection and watchdog pulses
 * that come from logic on clk.
 */
`timescale 1ns/100ps
module charger_config_status_regs (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port from the serial front end
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rd_valid,
	// same-clock events and values
	input wire logic detection_done,
	input wire logic watchdog_expired,
	input wire logic [11:0] resistor_current_ma,
	// asynchronous pin levels
	input wire charger_regs_pkg::pin_in_t pins,
	// decoded settings
	output logic [11:0] charge_ma,
	output logic use_resistor_current,
	output logic [11:0] term_ma,
	output logic [12:0] vin_mv,
	output logic use_resistor_vin,
	output logic timer_half_rate,
	output logic safety_timer_disable,
	output logic [9:0] fast_limit_min,
	output logic battery_switch_off,
	output logic thermistor_on,
	output logic [1:0] active_loop,
	output logic charge_suspend,
	output logic cold_charge_mode,
	output logic detect_start,
	output logic host_mode
);

	charger_regs_pkg::state_t st;
	charger_regs_pkg::state_t n;
	charger_regs_pkg::pin_in_t pins_s;
	logic [1:0] loop_now;
	logic loop_read;
	logic standalone;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	pin_sync #(
		.WIDTH($bits(charger_regs_pkg::pin_in_t))
	) u_pin_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(pins),
		.sync_out(pins_s)
	);

	// ----------------------------------------------------------------
	// loop arbitration
	// ----------------------------------------------------------------
	// thermal outranks the current limit, which outranks the voltage loop,
	// so that a single loop is named even when several comparators fire
	always_comb
	begin
		if (pins_s.thermal_regulation)
			loop_now = charger_regs_pkg::LOOP_THERMAL;
		else if (pins_s.input_current_limit)
			loop_now = charger_regs_pkg::LOOP_ILIM;
		else if (pins_s.input_voltage_regulation)
			loop_now = charger_regs_pkg::LOOP_VIN;
		else
			loop_now = charger_regs_pkg::LOOP_NONE;
	end

	assign loop_read = rd_en && (addr == charger_regs_pkg::ADDR_LOOP);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		n = st;
		n.rd_valid = 1'b0;
		n.detect_start = 1'b0;
		// host writes; read-only fields are never taken from wdata
		if (wr_en)
		begin
			n.host_mode = 1'b1;
			if (addr == charger_regs_pkg::ADDR_CHARGE)
				n.charge = wdata;
			else if (addr == charger_regs_pkg::ADDR_LOOP)
			begin
				n.loop.reduced_current_select = wdata[5];
				n.loop.input_voltage_threshold_code = wdata[2:0];
			end
			else if (addr == charger_regs_pkg::ADDR_TIMER)
			begin
				n.timer.timer_slowdown_enable = wdata[7];
				n.timer.safety_time_select = wdata[6:5];
				n.timer.battery_disconnect_enable = wdata[4];
				n.timer.thermistor_enable = wdata[3];
			end
		end
		else if (watchdog_expired)
			n.host_mode = 1'b0;
		// detection trigger: a new request wins over a completion
		if (wr_en && (addr == charger_regs_pkg::ADDR_LOOP) && wdata[4])
		begin
			n.loop.line_detect_trigger = 1'b1;
			n.detect_start = 1'b1;
		end
		else if (detection_done)
			n.loop.line_detect_trigger = 1'b0;
		// reads
		if (rd_en)
		begin
			n.rd_valid = 1'b1;
			if (addr == charger_regs_pkg::ADDR_CHARGE)
				n.rdata = st.charge;
			else if (addr == charger_regs_pkg::ADDR_LOOP)
				n.rdata = st.loop;
			else if (addr == charger_regs_pkg::ADDR_TIMER)
				n.rdata = st.timer;
			else
				n.rdata = charger_regs_pkg::UNMAPPED_READ;
		end
		// latched loop status: a read clears it, a live loop relatches at once
		if (loop_read)
			n.loop.loop_status = charger_regs_pkg::LOOP_NONE;
		if ((n.loop.loop_status == charger_regs_pkg::LOOP_NONE) &&
			(loop_now != charger_regs_pkg::LOOP_NONE))
			n.loop.loop_status = loop_now;
		n.active_loop = loop_now;
		n.loop.ce_mirror = pins_s.ce_pin_n;
		// thermistor fault code
		if (!n.timer.thermistor_enable || pins_s.ts_open)
			n.timer.thermistor_fault_code = charger_regs_pkg::TS_OPEN;
		else if (pins_s.freeze_handling_option && pins_s.ts_below_freeze)
			n.timer.thermistor_fault_code = charger_regs_pkg::TS_FROZEN;
		else if (pins_s.freeze_handling_option && pins_s.ts_below_cold)
			n.timer.thermistor_fault_code = charger_regs_pkg::TS_COOL_REDUCED;
		else if (pins_s.ts_below_cold)
			n.timer.thermistor_fault_code = charger_regs_pkg::TS_COLD;
		else
			n.timer.thermistor_fault_code = charger_regs_pkg::TS_NORMAL;
		n.thermistor_on = n.timer.thermistor_enable;
		n.charge_suspend = (n.timer.thermistor_fault_code == charger_regs_pkg::TS_COLD) ||
			(n.timer.thermistor_fault_code == charger_regs_pkg::TS_FROZEN);
		n.cold_charge_mode = (n.timer.thermistor_fault_code ==
			charger_regs_pkg::TS_COOL_REDUCED);
		// charge current and termination
		n.use_resistor_current = !n.host_mode || (&n.charge.charge_current_code);
		if (n.host_mode && n.loop.reduced_current_select)
			n.charge_ma = charger_regs_pkg::REDUCED_MA;
		else if (n.use_resistor_current)
			n.charge_ma = resistor_current_ma;
		else
			n.charge_ma = 12'(charger_regs_pkg::CHG_OFFSET_MA + charger_regs_pkg::CHG_STEP_MA *
				n.charge.charge_current_code);
		if (n.use_resistor_current)
			n.term_ma = 12'(resistor_current_ma / charger_regs_pkg::TERM_DIVISOR);
		else
			n.term_ma = 12'(charger_regs_pkg::TERM_OFFSET_MA + charger_regs_pkg::TERM_STEP_MA *
				n.charge.termination_threshold_code);
		// input voltage threshold
		n.use_resistor_vin = !n.host_mode;
		n.vin_mv = 13'(charger_regs_pkg::VIN_OFFSET_MV + charger_regs_pkg::VIN_STEP_MV *
			n.loop.input_voltage_threshold_code);
		// safety timer
		n.timer_half_rate = n.timer.timer_slowdown_enable && (pins_s.thermal_regulation ||
			pins_s.input_voltage_regulation || pins_s.power_path_regulation);
		n.safety_timer_disable = (n.timer.safety_time_select == charger_regs_pkg::TIMER_OFF);
		case (n.timer.safety_time_select)
			charger_regs_pkg::TIMER_SHORT: n.fast_limit_min = charger_regs_pkg::LIMIT_SHORT_MIN;
			charger_regs_pkg::TIMER_MEDIUM: n.fast_limit_min = charger_regs_pkg::LIMIT_MEDIUM_MIN;
			charger_regs_pkg::TIMER_LONG: n.fast_limit_min = charger_regs_pkg::LIMIT_LONG_MIN;
			default: n.fast_limit_min = 10'h000;
		endcase
		n.battery_switch_off = n.timer.battery_disconnect_enable &&
			!pins_s.input_power_present;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// decoded outputs reset to the values that the register reset implies
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.charge <= charger_regs_pkg::CHARGE_RST;
			st.loop <= charger_regs_pkg::LOOP_RST;
			st.timer <= charger_regs_pkg::TIMER_RST;
			st.timer.thermistor_fault_code <= charger_regs_pkg::TS_NORMAL;
			st.use_resistor_current <= 1'b1;
			st.use_resistor_vin <= 1'b1;
			st.vin_mv <= charger_regs_pkg::VIN_RST_MV;
			st.fast_limit_min <= charger_regs_pkg::LIMIT_MEDIUM_MIN;
			st.thermistor_on <= 1'b1;
		end
		else
			st <= n;
	end

	assign standalone = !st.host_mode;

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata = st.rdata;
	assign rd_valid = st.rd_valid;
	assign charge_ma = st.charge_ma;
	assign use_resistor_current = st.use_resistor_current;
	assign term_ma = st.term_ma;
	assign vin_mv = st.vin_mv;
	assign use_resistor_vin = st.use_resistor_vin;
	assign timer_half_rate = st.timer_half_rate;
	assign safety_timer_disable = st.safety_timer_disable;
	assign fast_limit_min = st.fast_limit_min;
	assign battery_switch_off = st.battery_switch_off;
	assign thermistor_on = st.thermistor_on;
	assign active_loop = st.active_loop;
	assign charge_suspend = st.charge_suspend;
	assign cold_charge_mode = st.cold_charge_mode;
	assign detect_start = st.detect_start;
	assign host_mode = st.host_mode;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence trigger_write_s;
		wr_en && (addr == charger_regs_pkg::ADDR_LOOP) && wdata[4];
	endsequence

	sequence run_started_s;
		st.detect_start && st.loop.line_detect_trigger ##1 !st.detect_start;
	endsequence

	charge_decode_a: assert property (st.host_mode && !st.loop.reduced_current_select &&
		!(&st.charge.charge_current_code) |-> st.charge_ma == 12'(12'h1F4 + 12'h032 *
		st.charge.charge_current_code))
		else $error("charge current decode wrong");

	resistor_mode_a: assert property (&n.charge.charge_current_code &&
		!(n.host_mode && n.loop.reduced_current_select) |=> st.use_resistor_current &&
		st.charge_ma == $past(resistor_current_ma))
		else $error("resistor charge mode not taken");

	term_decode_a: assert property (!st.use_resistor_current |->
		st.term_ma == 12'(12'h032 + 12'h019 * st.charge.termination_threshold_code))
		else $error("termination decode wrong");

	term_tenth_a: assert property (n.use_resistor_current |=>
		st.term_ma == 12'($past(resistor_current_ma) / 12'h00A))
		else $error("termination not ten percent");

	loop_hold_a: assert property (st.loop.loop_status != 2'h0 && !loop_read |=>
		$stable(st.loop.loop_status))
		else $error("loop status changed before read");

	loop_clear_a: assert property (loop_read && loop_now == 2'h0 |=>
		st.loop.loop_status == 2'h0 && st.rdata[7:6] == $past(st.loop.loop_status))
		else $error("loop status read did not clear");

	loop_first_a: assert property (st.loop.loop_status == 2'h0 && loop_now != 2'h0 |=>
		st.loop.loop_status == $past(loop_now))
		else $error("earliest loop not latched");

	single_loop_a: assert property (pins_s.thermal_regulation |=>
		st.active_loop == 2'h3)
		else $error("thermal loop not given priority");

	reduced_current_a: assert property (st.host_mode && st.loop.reduced_current_select |->
		st.charge_ma == 12'h14A)
		else $error("reduced current not applied");

	trigger_run_a: assert property (trigger_write_s |=> run_started_s)
		else $error("detection run not started once");

	trigger_done_a: assert property (detection_done && !(wr_en && addr == 8'h04) |=>
		!st.loop.line_detect_trigger)
		else $error("trigger not cleared on completion");

	ce_mirror_a: assert property (##1 st.loop.ce_mirror == $past(pins_s.ce_pin_n))
		else $error("charge enable mirror stale");

	vin_decode_a: assert property (st.vin_mv ==
		13'(13'h1068 + 13'h0050 * st.loop.input_voltage_threshold_code))
		else $error("input threshold decode wrong");

	half_rate_a: assert property (!n.timer.timer_slowdown_enable |=> !st.timer_half_rate)
		else $error("timer slowed while slowdown disabled");

	timer_off_a: assert property (st.timer.safety_time_select == 2'h3 |->
		st.safety_timer_disable && st.fast_limit_min == 10'h000)
		else $error("safety timer not disabled");

	ts_disabled_a: assert property (!st.timer.thermistor_enable |->
		st.timer.thermistor_fault_code == 3'h7 && !st.thermistor_on)
		else $error("disabled thermistor not reported open");

	switch_off_a: assert property (n.timer.battery_disconnect_enable &&
		!pins_s.input_power_present |=> st.battery_switch_off)
		else $error("battery switch not opened");

	standalone_a: assert property (watchdog_expired && !wr_en |=>
		standalone && st.use_resistor_current && st.use_resistor_vin)
		else $error("standalone not resumed after watchdog");

	ro_write_a: assert property (wr_en && addr == 8'h05 && !pins_s.ts_open &&
		n.timer.thermistor_enable && !pins_s.ts_below_cold && !pins_s.ts_below_freeze |=>
		st.timer.thermistor_fault_code == 3'h0)
		else $error("read-only field took write data");

endmodule

// File: charger_config_status_regs_test.sv
/*
 * Self-checking bench of the charger register bank.
 * Assumes host_port_model drives the register port.
 */
`timescale 1ns/100ps
`define CHECK(w, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s: expected %0h, seen %0h", w, e, g); end end
module charger_config_status_regs_test;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wr_en, rd_en, rd_valid, detection_done, watchdog_expired;
	logic [7:0] addr, wdata, rdata;
	logic [11:0] resistor_current_ma = 12'h2EE;
	charger_regs_pkg::pin_in_t pins = '0;
	logic [11:0] charge_ma, term_ma;
	logic [12:0] vin_mv;
	logic [9:0] fast_limit_min;
	logic [1:0] active_loop;
	logic use_resistor_current, use_resistor_vin, timer_half_rate, safety_timer_disable;
	logic battery_switch_off, thermistor_on, charge_suspend, cold_charge_mode;
	logic detect_start, host_mode;
	int fails = 0;
	int tests_run = 0;
	// {cold, freeze, open, option} above the expected three-bit fault code
	logic [6:0] ts_tab [6] = '{7'h00, 7'h44, 7'h4D, 7'h6E, 7'h17, 7'h07};
	logic [9:0] lim_tab [4] = '{10'h02D, 10'h168, 10'h21C, 10'h000};

	always #5 clk = ~clk;

	host_port_model host (.clk, .wr_en, .rd_en, .addr, .wdata, .rdata, .rd_valid);
	charger_config_status_regs DUT (.clk, .sys_rst, .wr_en, .rd_en, .addr, .wdata,
		.rdata, .rd_valid, .detection_done, .watchdog_expired, .resistor_current_ma,
		.pins, .charge_ma, .use_resistor_current, .term_ma, .vin_mv, .use_resistor_vin,
		.timer_half_rate, .safety_timer_disable, .fast_limit_min, .battery_switch_off,
		.thermistor_on, .active_loop, .charge_suspend, .cold_charge_mode,
		.detect_start, .host_mode);

	task automatic summarize();
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// pins pass two sync flops and one register
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.read_reg(a, d, v);
		`CHECK("read valid", 1'b1, v);
		`CHECK("read data", e, d & m);
	endtask

	task automatic loops(input logic [2:0] v);
		{pins.input_voltage_regulation, pins.input_current_limit, pins.thermal_regulation} = v;
		settle();
	endtask

	task automatic pulse(input bit wd);
		@(negedge clk);
		if (wd)
			watchdog_expired = 1'b1;
		else
			detection_done = 1'b1;
		@(negedge clk);
		watchdog_expired = 1'b0;
		detection_done = 1'b0;
	endtask

	initial
	begin
		#100000;
		fails++;
		summarize();
	end

	initial
	begin
		detection_done = 1'b0;
		watchdog_expired = 1'b0;
		pins.input_power_present = 1'b1;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		settle();
		// ----------------------------------------------------------------
		// reset values and standalone mode
		// ----------------------------------------------------------------
		rd(8'h03, 8'hFF, 8'hF8);
		rd(8'h04, 8'hFF, 8'h02);
		rd(8'h05, 8'hFF, 8'hA8);
		`CHECK("host mode", 1'b0, host_mode);
		`CHECK("charge", 12'h2EE, charge_ma);
		`CHECK("vin source", 1'b1, use_resistor_vin);
		host.write_reg(8'h07, 8'h55);
		rd(8'h07, 8'hFF, 8'h00);
		`CHECK("host mode", 1'b1, host_mode);
		// ----------------------------------------------------------------
		// charge and termination decode
		// ----------------------------------------------------------------
		for (int i = 0; i < 31; i++)
		begin
			host.write_reg(8'h03, {5'(i), 3'(i)});
			`CHECK("charge", 12'h1F4 + 12'h032 * 12'(i), charge_ma);
			`CHECK("term", 12'h032 + 12'h019 * 12'(i % 8), term_ma);
			`CHECK("resistor mode", 1'b0, use_resistor_current);
		end
		host.write_reg(8'h03, 8'hFD);
		`CHECK("resistor mode", 1'b1, use_resistor_current);
		`CHECK("charge", 12'h2EE, charge_ma);
		`CHECK("term", 12'h04B, term_ma);
		host.write_reg(8'h03, 8'h55);
		host.write_reg(8'h04, 8'h20);
		`CHECK("charge", 12'h14A, charge_ma);
		rd(8'h04, 8'h3F, 8'h20);
		for (int i = 0; i < 8; i++)
		begin
			host.write_reg(8'h04, 8'(i));
			`CHECK("vin", 13'h1068 + 13'h0050 * 13'(i), vin_mv);
		end
		`CHECK("charge", 12'h3E8, charge_ma);
		host.write_reg(8'h04, 8'hC8);
		rd(8'h04, 8'hFF, 8'h00);
		// ----------------------------------------------------------------
		// detection trigger and charge-enable mirror
		// ----------------------------------------------------------------
		host.write_reg(8'h04, 8'h10);
		`CHECK("detect start", 1'b1, detect_start);
		rd(8'h04, 8'h10, 8'h10);
		pulse(1'b0);
		rd(8'h04, 8'h10, 8'h00);
		pins.ce_pin_n = 1'b1;
		settle();
		rd(8'h04, 8'h08, 8'h08);
		pins.ce_pin_n = 1'b0;
		settle();
		rd(8'h04, 8'h08, 8'h00);
		// ----------------------------------------------------------------
		// loop status latch and timer slowdown
		// ----------------------------------------------------------------
		for (int k = 1; k < 4; k++)
		begin
			loops(3'b100 >> (k - 1));
			`CHECK("active loop", 2'(k), active_loop);
			loops(3'b000);
			rd(8'h04, 8'hC0, {2'(k), 6'h00});
			rd(8'h04, 8'hC0, 8'h00);
		end
		loops(3'b100);
		`CHECK("half rate", 1'b1, timer_half_rate);
		host.write_reg(8'h05, 8'h28);
		`CHECK("half rate", 1'b0, timer_half_rate);
		host.write_reg(8'h05, 8'hA8);
		loops(3'b101);
		`CHECK("active loop", 2'h3, active_loop);
		loops(3'b000);
		rd(8'h04, 8'hC0, 8'h40);
		pins.power_path_regulation = 1'b1;
		settle();
		`CHECK("half rate", 1'b1, timer_half_rate);
		pins.power_path_regulation = 1'b0;
		// ----------------------------------------------------------------
		// timer, thermistor and battery switch
		// ----------------------------------------------------------------
		for (int t = 0; t < 4; t++)
		begin
			host.write_reg(8'h05, {1'b1, 2'(t), 5'h08});
			`CHECK("time limit", lim_tab[t], fast_limit_min);
			`CHECK("timer off", t == 3, safety_timer_disable);
		end
		host.write_reg(8'h05, 8'hAF);
		rd(8'h05, 8'hFF, 8'hA8);
		for (int j = 0; j < 6; j++)
		begin
			if (j == 5)
				host.write_reg(8'h05, 8'hA0);
			{pins.ts_below_cold, pins.ts_below_freeze, pins.ts_open,
				pins.freeze_handling_option} = ts_tab[j][6:3];
			settle();
			rd(8'h05, 8'h07, {5'h00, ts_tab[j][2:0]});
			`CHECK("suspend", ts_tab[j][2:0] inside {3'h4, 3'h6}, charge_suspend);
			`CHECK("cold mode", ts_tab[j][2:0] == 3'h5, cold_charge_mode);
			`CHECK("ts on", j != 5, thermistor_on);
		end
		host.write_reg(8'h05, 8'h38);
		`CHECK("switch off", 1'b0, battery_switch_off);
		pins.input_power_present = 1'b0;
		settle();
		`CHECK("switch off", 1'b1, battery_switch_off);
		// ----------------------------------------------------------------
		// watchdog returns to standalone
		// ----------------------------------------------------------------
		pulse(1'b1);
		`CHECK("host mode", 1'b0, host_mode);
		`CHECK("vin source", 1'b1, use_resistor_vin);
		`CHECK("resistor mode", 1'b1, use_resistor_current);
		summarize();
	end
endmodule

// File: charger_regs_pkg.sv
/*
 * Shared constants and types of the charger configuration and status registers:
 * register locations, reset values, field layouts, decode offsets and steps,
 * loop and thermistor codes, and the packed state carried by the register bank.
 * Assumes one 100 MHz clock domain and a byte-wide register port fed by the
 * serial front end.
 */
// What this block does
// - charge code: 500 mA plus 50 mA steps
// - all-ones charge code selects resistor current
// - termination code: 50 mA plus 25 mA steps
// - resistor mode: termination is ten percent
// - loop status codes none, vin, ilim, thermal
// - loop status holds until read, read clears
// - several loop events: earliest one reported
// - only one regulation loop reported at once
// - reduced select forces 330 mA charge current
// - trigger starts detection, clears when done
// - mirror bit follows the charge enable pin
// - vin code: 4.20 V plus 80 mV steps
// - slowdown halves timer in thermal, vin and power-path regulation
// - timer select: 0.75, 6, 9 h, off
// - thermistor enable bit turns monitoring on
// - disconnect bit opens battery switch without input
// - standalone until first write, again after watchdog
package charger_regs_pkg;

	// ----------------------------------------------------------------
	// register locations and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CHARGE = 8'h03;
	localparam logic [7:0] ADDR_LOOP = 8'h04;
	localparam logic [7:0] ADDR_TIMER = 8'h05;
	localparam logic [7:0] CHARGE_RST = 8'hF8;
	localparam logic [7:0] LOOP_RST = 8'h02;
	localparam logic [7:0] TIMER_RST = 8'hA8;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------------------------------
	// decode offsets and steps
	// ----------------------------------------------------------------
	localparam logic [11:0] CHG_OFFSET_MA = 12'h1F4;
	localparam logic [11:0] CHG_STEP_MA = 12'h032;
	localparam logic [11:0] REDUCED_MA = 12'h14A;
	localparam logic [11:0] TERM_OFFSET_MA = 12'h032;
	localparam logic [11:0] TERM_STEP_MA = 12'h019;
	localparam logic [11:0] TERM_DIVISOR = 12'h00A;
	localparam logic [12:0] VIN_OFFSET_MV = 13'h1068;
	localparam logic [12:0] VIN_STEP_MV = 13'h0050;
	// threshold implied by the reset code of the input voltage field
	localparam logic [12:0] VIN_RST_MV = 13'h1108;

	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [1:0] LOOP_NONE = 2'h0;
	localparam logic [1:0] LOOP_VIN = 2'h1;
	localparam logic [1:0] LOOP_ILIM = 2'h2;
	localparam logic [1:0] LOOP_THERMAL = 2'h3;
	localparam logic [1:0] TIMER_SHORT = 2'h0;
	localparam logic [1:0] TIMER_MEDIUM = 2'h1;
	localparam logic [1:0] TIMER_LONG = 2'h2;
	localparam logic [1:0] TIMER_OFF = 2'h3;
	localparam logic [9:0] LIMIT_SHORT_MIN = 10'h02D;
	localparam logic [9:0] LIMIT_MEDIUM_MIN = 10'h168;
	localparam logic [9:0] LIMIT_LONG_MIN = 10'h21C;
	localparam logic [2:0] TS_NORMAL = 3'h0;
	localparam logic [2:0] TS_COLD = 3'h4;
	localparam logic [2:0] TS_COOL_REDUCED = 3'h5;
	localparam logic [2:0] TS_FROZEN = 3'h6;
	localparam logic [2:0] TS_OPEN = 3'h7;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] charge_current_code;
		logic [2:0] termination_threshold_code;
	} charge_reg_t;

	typedef struct packed {
		logic [1:0] loop_status;
		logic reduced_current_select;
		logic line_detect_trigger;
		logic ce_mirror;
		logic [2:0] input_voltage_threshold_code;
	} loop_reg_t;

	typedef struct packed {
		logic timer_slowdown_enable;
		logic [1:0] safety_time_select;
		logic battery_disconnect_enable;
		logic thermistor_enable;
		logic [2:0] thermistor_fault_code;
	} timer_reg_t;

	// pin-level inputs, all asynchronous to clk
	typedef struct packed {
		logic ce_pin_n;
		logic input_power_present;
		logic input_voltage_regulation;
		logic input_current_limit;
		logic thermal_regulation;
		logic power_path_regulation;
		logic ts_below_cold;
		logic ts_below_freeze;
		logic ts_open;
		logic freeze_handling_option;
	} pin_in_t;

	typedef struct packed {
		charge_reg_t charge;
		loop_reg_t loop;
		timer_reg_t timer;
		logic host_mode;
		logic [7:0] rdata;
		logic rd_valid;
		logic detect_start;
		logic [11:0] charge_ma;
		logic use_resistor_current;
		logic [11:0] term_ma;
		logic [12:0] vin_mv;
		logic use_resistor_vin;
		logic timer_half_rate;
		logic safety_timer_disable;
		logic [9:0] fast_limit_min;
		logic battery_switch_off;
		logic thermistor_on;
		logic [1:0] active_loop;
		logic charge_suspend;
		logic cold_charge_mode;
	} state_t;

endpackage

// File: host_port_model.sv
/*
 * Host-side model of the byte register port, with write and read tasks.
 * Assumes the block takes requests on the rising edge of clk.
 */
`timescale 1ns/100ps
module host_port_model (
	// clock
	input wire logic clk,
	// register port
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rd_valid
);
	initial
	begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end

	// idle address and data are inverted so a stale value never passes
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr_en = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask

	// status is read before it is trusted, which also clears it
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		rd_en = 1'b1;
		addr = a;
		@(negedge clk);
		d = rdata;
		v = rd_valid;
		rd_en = 1'b0;
		addr = ~a;
	endtask
endmodule

// File: pin_sync.sv
/*
 * Two-stage synchroniser for a bundle of asynchronous level inputs.
 * Assumes every bit is a slow level; pulses shorter than one clock may be lost.
 */
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st;
	sync_state_t n;

	if (WIDTH < 1)
	begin : width_check
		$error("pin_sync needs at least one bit");
	end

	// the first stage feeds only the second stage
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_comb
		begin
			n.meta[i] = async_in[i];
			n.stable[i] = st.meta[i];
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= n;
	end

	assign sync_out = st.stable;

endmodule
